/* File: hw/acrg_top.v */
// Converter clock tree, data rate generator and correction words
`timescale 1ns/1ps
`default_nettype none
`include "acrg_defs.vh"
module acrg_top #(
   parameter WORD_W = `ACRG_WORD_W,
   parameter NCH    = `ACRG_CHANNELS
) (
   // Clock and reset
   input  wire                  clk_sys,
   input  wire                  sys_rst,
   // Clock source select
   input  wire                  externalClockSelect,
   input  wire                  crystalClockTick,
   input  wire                  extClockTick,
   // Configuration
   input  wire                  cfgLoad,
   input  wire [1:0]            prescaleSelect,
   input  wire [2:0]            oversamplingSelect,
   // Correction words, one load strobe per channel
   input  wire [NCH-1:0]        corrLoad,
   input  wire [NCH*WORD_W-1:0] offsetCorrectionIn,
   input  wire [NCH*WORD_W-1:0] gainCorrectionIn,
   // Raw modulator results, valid with the result tick
   input  wire [NCH*WORD_W-1:0] rawResult,
   // Clocks as one-cycle ticks
   output wire                  analogMasterClock,
   output wire                  sampleClock,
   output wire                  outputRateClock,
   output reg                   newSampleStrobe_n_ff,
   // Status
   output reg  [1:0]            prescaleState_ff,
   output reg  [2:0]            oversamplingState_ff,
   output reg  [NCH*WORD_W-1:0] offsetCorrectionWord_ff,
   output reg  [NCH*WORD_W-1:0] gainCorrectionWord_ff,
   output reg  [NCH*WORD_W-1:0] correctedResult_ff
);
   localparam CW = `ACRG_CNT_W;

   // ----------------------------------------------------------------
   // Ratio decode
   // ----------------------------------------------------------------
   // Both limits are the ratio minus one, matching the dividers' compare
   function [CW-1:0] preMinusOne;
      input [1:0]    code;
      reg   [CW-1:0] full;
      begin
         full        = {{(CW-1){1'b0}}, 1'b1} << code;
         preMinusOne = full - {{(CW-1){1'b0}}, 1'b1};
      end
   endfunction

   function [CW-1:0] osrMinusOne;
      input [2:0] code;
      reg   [CW:0] full;
      begin
         full        = {{CW{1'b0}}, 1'b1} << (code + `ACRG_OSR_MIN_LOG2);
         osrMinusOne = full[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      end
   endfunction

   // ----------------------------------------------------------------
   // Master clock selection
   // ----------------------------------------------------------------
   reg masterTick;

   // Both sources arrive as ticks in the one system clock domain
   always @* begin
      case (externalClockSelect)
         1'b0: begin
            masterTick = crystalClockTick;
         end
         1'b1: begin
            masterTick = extClockTick;
         end
         default: begin
            masterTick = crystalClockTick;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         prescaleState_ff     <= `ACRG_PRESCALE_RST;
         oversamplingState_ff <= `ACRG_OSR_RST;
      end else if (cfgLoad) begin
         prescaleState_ff     <= prescaleSelect;
         oversamplingState_ff <= oversamplingSelect;
      end
   end

   // ----------------------------------------------------------------
   // Divider chain
   // ----------------------------------------------------------------
   // Ticks are gated with reset so no clock is distributed while held
   wire [CW-1:0] preDiv;
   wire [CW-1:0] smpDiv;
   wire [CW-1:0] rateDiv;
   wire [31:0]   smpDivFull;
   wire          preRun;
   wire          smpRun;
   wire          rateRun;
   assign preRun     = masterTick & ~sys_rst;
   assign smpRun     = analogMasterClock;
   assign rateRun    = sampleClock;
   assign preDiv     = preMinusOne(prescaleState_ff);
   // The integer limit is small, so its upper bits are dropped on purpose
   assign smpDivFull = `ACRG_SAMPLE_DIV - 1;
   assign smpDiv     = smpDivFull[CW-1:0];
   assign rateDiv    = osrMinusOne(oversamplingState_ff);

   // Prescaler: counted master ticks become the analog clock
   acrg_divider #(.CNT_W(CW)) uPre (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .runEn       (preRun),
      .divMinusOne (preDiv),
      .tickOut_ff  (analogMasterClock)
   );

   // Fixed divide by four gives the sample clock
   acrg_divider #(.CNT_W(CW)) uSmp (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .runEn       (smpRun),
      .divMinusOne (smpDiv),
      .tickOut_ff  (sampleClock)
   );

   // A new ratio takes effect at the next compare, no restart needed
   acrg_divider #(.CNT_W(CW)) uOsr (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .runEn       (rateRun),
      .divMinusOne (rateDiv),
      .tickOut_ff  (outputRateClock)
   );

   // ----------------------------------------------------------------
   // Correction words and result path
   // ----------------------------------------------------------------
   // Each channel loads on its own strobe so one can be trimmed alone
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch = ch + 1) begin : gStore
         wire [WORD_W-1:0] offNew;
         wire [WORD_W-1:0] gainNew;
         assign offNew  = offsetCorrectionIn[ch*WORD_W +: WORD_W];
         assign gainNew = gainCorrectionIn[ch*WORD_W +: WORD_W];

         always @(posedge clk_sys) begin
            if (sys_rst) begin
               offsetCorrectionWord_ff[ch*WORD_W +: WORD_W] <= `ACRG_CORR_RST;
               gainCorrectionWord_ff[ch*WORD_W +: WORD_W]   <= `ACRG_CORR_RST;
            end else if (corrLoad[ch]) begin
               offsetCorrectionWord_ff[ch*WORD_W +: WORD_W] <= offNew;
               gainCorrectionWord_ff[ch*WORD_W +: WORD_W]   <= gainNew;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Result path
   // ----------------------------------------------------------------
   // Gain word is a signed fraction; unity plus gn over 2^(W-1)
   // Results wrap rather than saturate when the trim overdrives them
   generate
      for (ch = 0; ch < NCH; ch = ch + 1) begin : gResult
         wire signed [WORD_W-1:0]   raw;
         wire signed [WORD_W-1:0]   off;
         wire signed [WORD_W-1:0]   gn;
         wire signed [WORD_W:0]     sum;
         wire signed [2*WORD_W+1:0] prod;
         wire signed [WORD_W-1:0]   scaled;

         assign raw    = rawResult[ch*WORD_W +: WORD_W];
         assign off    = offsetCorrectionWord_ff[ch*WORD_W +: WORD_W];
         assign gn     = gainCorrectionWord_ff[ch*WORD_W +: WORD_W];
         assign sum    = {raw[WORD_W-1], raw} + {off[WORD_W-1], off};
         assign prod   = sum * $signed({gn[WORD_W-1], gn});
         assign scaled = sum[WORD_W-1:0] + prod[2*WORD_W-2:WORD_W-1];

         always @(posedge clk_sys) begin
            if (sys_rst) begin
               correctedResult_ff[ch*WORD_W +: WORD_W] <= `ACRG_CORR_RST;
            end else if (outputRateClock) begin
               correctedResult_ff[ch*WORD_W +: WORD_W] <= scaled;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Data-ready strobe
   // ----------------------------------------------------------------
   // Pulse lands with the corrected result so the host reads fresh data
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         newSampleStrobe_n_ff <= 1'b1;
      end else begin
         newSampleStrobe_n_ff <= ~outputRateClock;
      end
   end
endmodule
`default_nettype wire

/* File: hw/acrg_defs.vh */
// Constants for the converter clock and rate generator
`ifndef ACRG_DEFS_VH
`define ACRG_DEFS_VH

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACRG_PRESCALE_RST   2'h0
`define ACRG_OSR_RST        3'h3
`define ACRG_CORR_RST       24'h000000

// ----------------------------------------------------------------
// Divider figures, word width and channel count
// ----------------------------------------------------------------
`define ACRG_SAMPLE_DIV     4
`define ACRG_OSR_MIN_LOG2   5
`define ACRG_CNT_W          12
`define ACRG_WORD_W         24
`define ACRG_CHANNELS       3

`endif

/* File: hw/acrg_divider.v */
// Programmable divider producing a one-cycle tick every divMinusOne plus one enabled cycles
`timescale 1ns/1ps
`default_nettype none
module acrg_divider #(
   parameter CNT_W = 12
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             sys_rst,
   // Control
   input  wire             runEn,
   input  wire [CNT_W-1:0] divMinusOne,
   // Output
   output reg              tickOut_ff
);
   reg [CNT_W-1:0] count_ff;
   wire            wrap;

   assign wrap = (count_ff >= divMinusOne);

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         count_ff   <= {CNT_W{1'b0}};
         tickOut_ff <= 1'b0;
      end else if (runEn) begin
         // Compare with >= so a smaller ratio never strands the count
         count_ff   <= wrap ? {CNT_W{1'b0}} : count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
         tickOut_ff <= wrap;
      end else begin
         tickOut_ff <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: verif/acrg_clk_source.sv */
// Master clock source model
`timescale 1ns/1ps
`default_nettype none
module acrg_clk_source (
   // Clock
   input  wire logic clk_sys,
   // Master ticks
   output var  logic crystalClockTick,
   output var  logic extClockTick
);
   // Crystal is prompt, the external input slow; both run without pause
   initial crystalClockTick = 1'h1;
   always @(posedge clk_sys) begin
      extClockTick <= #1 (extClockTick !== 1'h1);
   end
endmodule
`default_nettype wire

/* File: verif/acrg_top_monitor.sv */
// Assertion checker for the clock and rate generator
`timescale 1ns/1ps
`default_nettype none
module acrg_top_monitor (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   // Watched ports
   input wire logic       cfgLoad,
   input wire logic [2:0] oversamplingSelect,
   input wire logic [1:0] prescaleSelect,
   input wire logic [1:0] prescaleState_ff,
   input wire logic       analogMasterClock,
   input wire logic       sampleClock,
   input wire logic       outputRateClock,
   input wire logic       newSampleStrobe_n_ff,
   input wire logic [2:0] oversamplingState_ff
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_reset_quiet: assert property (disable iff (1'h0) sys_rst |=> !sampleClock)
      else $error("tick in reset");
   a_reset_dflt: assert property (disable iff (1'h0)
      sys_rst |=> oversamplingState_ff == 3'h3) else $error("bad ratio default");
   a_cfg_latch: assert property (cfgLoad |=>
      oversamplingState_ff == $past(oversamplingSelect)) else $error("ratio not latched");
   a_pre_latch: assert property (cfgLoad |=> prescaleState_ff == $past(prescaleSelect))
      else $error("prescale not latched");
   a_pre_dflt: assert property (disable iff (1'h0) sys_rst |=> prescaleState_ff == 2'h0)
      else $error("bad prescale default");
   a_amc_quiet: assert property (disable iff (1'h0) sys_rst |=> !analogMasterClock)
      else $error("analog tick in reset");
   a_rate_strobe: assert property (outputRateClock |=> !newSampleStrobe_n_ff)
      else $error("no strobe");
   a_strobe_width: assert property (!newSampleStrobe_n_ff |=> newSampleStrobe_n_ff)
      else $error("long strobe");
   a_sample_cause: assert property (sampleClock |-> $past(analogMasterClock))
      else $error("stray sample tick");
   a_rate_cause: assert property (outputRateClock |-> $past(sampleClock))
      else $error("stray rate tick");
   a_sample_gap: assert property (sampleClock |=> !sampleClock [*3])
      else $error("sample ticks too close");
endmodule
bind acrg_top acrg_top_monitor i_acrg_top_monitor (.*);
`default_nettype wire

/* File: verif/acrg_top_test.sv */
// Testbench for the clock and rate generator
`timescale 1ns/1ps
`default_nettype none
module acrg_top_test;
   logic        clk_sys = 1'h0;
   logic        sys_rst = 1'h1;
   logic        extSel = 1'h0;
   logic        cfgLoad = 1'h0;
   logic [1:0]  pre = 2'h0;
   logic [2:0]  osr = 3'h3;
   logic [2:0]  corrLoad = 3'h0;
   logic [71:0] offIn = 72'h0;
   logic [71:0] gainIn = 72'h0;
   logic [71:0] raw = {3{24'h64}};
   wire         crys, ext, orc, ready_n;
   wire  [2:0]  osrSt;
   wire  [1:0]  preSt;
   wire  [71:0] offW, gainW, corr;
   int          bad_count = 0;
   int          n_compared = 0;
   int          relCount = 0;
   always #12.5 clk_sys = ~clk_sys;
   acrg_clk_source i_acrg_clk_source (.clk_sys(clk_sys), .crystalClockTick(crys),
      .extClockTick(ext));
   acrg_top i_acrg_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .externalClockSelect(extSel),
      .crystalClockTick(crys), .extClockTick(ext), .cfgLoad(cfgLoad), .prescaleSelect(pre),
      .oversamplingSelect(osr), .corrLoad(corrLoad), .offsetCorrectionIn(offIn),
      .gainCorrectionIn(gainIn), .rawResult(raw), .analogMasterClock(), .sampleClock(),
      .outputRateClock(orc), .newSampleStrobe_n_ff(ready_n), .prescaleState_ff(preSt),
      .oversamplingState_ff(osrSt), .offsetCorrectionWord_ff(offW),
      .gainCorrectionWord_ff(gainW), .correctedResult_ff(corr));
   task automatic check(string what, logic [71:0] exp, logic [71:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic test_done;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // First period after a load is partial, so the second one is timed
   task automatic period(logic [1:0] p, logic [2:0] o, logic e);
      int n;
      {pre, osr, extSel, cfgLoad} = {p, o, e, 1'h1};
      @(posedge clk_sys);
      #1 cfgLoad = 1'h0;
      check("prescale state", p, preSt);
      repeat (2) begin
         n = 0;
         do @(posedge clk_sys) #1 n++;
         while (orc !== 1'h1 && n < 40000);
      end
      if (orc !== 1'h1) begin
         check("rate tick", 1'h1, orc);
         test_done;
      end
      check("period", (e + 1) * 4 * (32 << o) << p, n);
      @(posedge clk_sys);
      #1 check("ready", 1'h0, ready_n);
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      #1 sys_rst = 1'h0;
      check("reset ratio", 3'h3, osrSt);
      check("reset offset", 72'h0, offW);
      offIn = {24'h0, 24'h14, 24'h14};
      gainIn = {24'h0, 24'h400000, 24'h0};
      corrLoad = 3'h3;
      @(posedge clk_sys);
      #1 corrLoad = 3'h0;
      check("offset", {24'h0, 24'h14, 24'h14}, offW);
      check("gain", {24'h0, 24'h400000, 24'h0}, gainW);
      for (int k = 0; k < 8; k++) period(2'h0, k[2:0], 1'h0);
      check("result", {24'h64, 24'hb4, 24'h78}, corr);
      for (int k = 1; k < 4; k++) period(k[1:0], 3'h0, 1'h0);
      period(2'h3, 3'h0, 1'h1);
      sys_rst = 1'h1;
      @(posedge clk_sys);
      #1 check("held ratio", 3'h3, osrSt);
      check("held prescale", 2'h0, preSt);
      {extSel, sys_rst} = 2'h0;
      do @(posedge clk_sys) #1 relCount++;
      while (orc !== 1'h1 && relCount < 2000);
      // Two register stages add to the 1024 counted master ticks
      check("first rate tick", 4 * 256 + 2, relCount);
      test_done;
   end
endmodule
`default_nettype wire
